// ==== src/can_fifo_filter_regs.sv ====
// The implementer's own choices: the register offsets and the Wishbone register port.
module can_fifo_filter_regs (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [8:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // frame identifier from the protocol engine
  input  wire logic [28:0] rx_id_i,
  input  wire logic        rx_ext_i,
  // per fifo events from the protocol engine
  input  wire logic [15:0] can_step_i,
  input  wire logic [15:0] tx_done_i,
  input  wire logic [15:0] tx_abort_i,
  input  wire logic [15:0] tx_lost_i,
  input  wire logic [15:0] tx_err_i,
  // filter hits and configuration towards the protocol engine
  output logic      [15:0] filter_hit_o,
  output logic      [15:0] fifo_tx_o,
  output logic      [15:0] payload_only_o,
  output logic      [2:0]  op_mode_o
);

  localparam int N = can_fifo_filter_pkg::N_CH;

  //////////////////////////////////////////////////////////////////////////
  // state
  logic        ack_q;
  logic [31:0] dat_q;
  logic [2:0]  mode_q;
  logic [15:0] fen_q;
  logic [15:0] hit_q;
  logic [31:0] flt_q   [N];
  logic [4:0]  depth_q [N];
  logic [4:0]  uidx_q  [N];
  logic [4:0]  cidx_q  [N];
  logic [N-1:0] clr_q;
  logic [N-1:0] ponly_q;
  logic [N-1:0] dir_q;
  logic [N-1:0] abt_q;
  logic [N-1:0] lost_q;
  logic [N-1:0] err_q;
  logic [31:0] ctl_w   [N];
  logic [31:0] uaddr_w [N];

  //////////////////////////////////////////////////////////////////////////
  // bus decode; ack comes one cycle after the request, write lands with it
  wire         req_w   = cyc_i & stb_i;
  wire         fire_w  = req_w & ack_q;
  wire         wr_w    = fire_w & we_i;
  wire         rd_w    = fire_w & ~we_i;
  wire  [3:0]  idx_w   = adr_i[5:2];
  wire  [2:0]  rgn_w   = adr_i[8:6];
  wire         cfg_w   = (mode_q == can_fifo_filter_pkg::MODE_CFG);
  wire         hit_flt = (rgn_w == can_fifo_filter_pkg::OFF_FILTER[8:6]);
  wire         hit_ctl = (rgn_w == can_fifo_filter_pkg::OFF_CTRL[8:6]);
  wire         hit_up  = (rgn_w == can_fifo_filter_pkg::OFF_UPTR[8:6]);
  wire         hit_ci  = (rgn_w == can_fifo_filter_pkg::OFF_CIDX[8:6]);
  wire         hit_md  = (adr_i == can_fifo_filter_pkg::OFF_MODE);
  wire         hit_fe  = (adr_i == can_fifo_filter_pkg::OFF_FEN);
  wire  [31:0] bmask_w = {{8{sel_i[3]}}, {8{sel_i[2]}},
                          {8{sel_i[1]}}, {8{sel_i[0]}}};

  // read mux; unmapped words read as zero and still get an ack
  wire  [31:0] rdata_w =
      hit_flt ? flt_q[idx_w] :
      hit_ctl ? ctl_w[idx_w] :
      hit_up  ? uaddr_w[idx_w] :
      hit_ci  ? {27'h000_0000, cidx_q[idx_w]} :
      hit_md  ? {29'h0000_0000, mode_q} :
      hit_fe  ? {16'h0000, fen_q} :
      32'h0000_0000;

  // byte-lane merge of write data into the current word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m_v);
    merge = (old_v & ~m_v) | (new_v & m_v);
  endfunction : merge

  // enable word with write data merged in; only the low half is kept
  wire  [31:0] fen_w   = merge({16'h0000, fen_q}, dat_i, bmask_w);

  //////////////////////////////////////////////////////////////////////////
  // bus handshake and shared registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      dat_q  <= 32'h0000_0000;
      mode_q <= can_fifo_filter_pkg::MODE_RST;
      fen_q  <= 16'h0000;
    end else begin
      ack_q <= req_w & ~ack_q;
      dat_q <= rdata_w;
      if (wr_w && hit_md && sel_i[0]) begin
        mode_q <= dat_i[2:0];
      end
      if (wr_w && hit_fe) begin
        fen_q <= fen_w[15:0];
      end
    end
  end

  assign ack_o     = ack_q;
  assign dat_o     = dat_q;
  assign op_mode_o = mode_q;

  // bus read data checks; dat_o stands in the ack cycle, so look there
  a_ptr_align: // [RQ15]
    assert property (@(posedge clk_i) disable iff (rst_i)
      rd_w && hit_up |-> dat_o[1:0] == 2'b00)
    else $error("user pointer read with low bits set");

  a_index_width: // [RQ17] [RQ18]
    assert property (@(posedge clk_i) disable iff (rst_i)
      rd_w && hit_ci |-> dat_o[31:5] == 27'h000_0000)
    else $error("side index read with upper bits set");

  //////////////////////////////////////////////////////////////////////////
  // per channel filter and fifo logic
  for (genvar g = 0; g < N; g++) begin : g_ch

    // filter compare; extended ids carry the standard part in the top 11
    wire std_eq = (rx_id_i[28:18] == flt_q[g][can_fifo_filter_pkg::STD_HI:
                                              can_fifo_filter_pkg::STD_LO]); // [RQ1]
    wire typ_eq = (rx_ext_i == flt_q[g][can_fifo_filter_pkg::EXT_BIT]); // [RQ2]
    wire ext_eq = (rx_id_i[17:0] == flt_q[g][can_fifo_filter_pkg::EXT_HI:0]); // [RQ3]
    wire match  = fen_q[g] & typ_eq & std_eq & (~rx_ext_i | ext_eq); // [RQ20]

    // access strobes for this channel
    wire wr_flt = wr_w & hit_flt & (idx_w == 4'(g));
    wire wr_ctl = wr_w & hit_ctl & (idx_w == 4'(g));
    wire rd_ctl = rd_w & hit_ctl & (idx_w == 4'(g));
    wire [31:0] nctl = merge(ctl_w[g], dat_i, bmask_w);
    wire adv    = wr_ctl & nctl[can_fifo_filter_pkg::ADV_BIT];
    wire [4:0] nd = nctl[can_fifo_filter_pkg::DEPTH_LO +: 5];

    // wrap at the last slot; depth code n means n+1 messages
    wire [4:0] unxt = (uidx_q[g] == depth_q[g]) ? 5'h00 : uidx_q[g] + 5'h01;
    wire [4:0] cnxt = (cidx_q[g] == depth_q[g]) ? 5'h00 : cidx_q[g] + 5'h01;

    // control word as software sees it; the advance bit reads back zero
    assign ctl_w[g] = {11'h000, depth_q[g], 1'b0, clr_q[g], 1'b0, ponly_q[g],
                       4'h0, dir_q[g], abt_q[g], lost_q[g], err_q[g], 4'h0};

    // rx payload-only slots are half size so more messages fit the span
    wire [31:0] slot = (ponly_q[g] & ~dir_q[g]) ? can_fifo_filter_pkg::SLOT_DATA
                                               : can_fifo_filter_pkg::SLOT_FULL; // [RQ9]
    // user index is the head on tx and the tail on rx
    wire [31:0] ua = can_fifo_filter_pkg::MSG_BASE
                     + 32'(g) * can_fifo_filter_pkg::FIFO_SPAN
                     + {27'h000_0000, uidx_q[g]} * slot; // [RQ13] [RQ14]
    assign uaddr_w[g] = {ua[31:2], 2'b00}; // [RQ15]

    // filter registers; a write to an enabled filter is dropped
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flt_q[g] <= can_fifo_filter_pkg::FLT_RST;
        hit_q[g] <= 1'b0;
      end else begin
        hit_q[g] <= match;
        if (wr_flt && !fen_q[g]) begin // [RQ4]
          flt_q[g] <= merge(flt_q[g], dat_i, bmask_w)
                      & can_fifo_filter_pkg::FLT_MASK;
        end
      end
    end

    // fifo configuration; depth and payload-only need configuration mode
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        depth_q[g] <= can_fifo_filter_pkg::DEPTH_RST;
        ponly_q[g] <= 1'b0;
        dir_q[g]   <= 1'b0;
      end else if (wr_ctl) begin
        dir_q[g] <= nctl[can_fifo_filter_pkg::DIR_BIT]; // [RQ19]
        if (cfg_w) begin // [RQ10]
          ponly_q[g] <= nctl[can_fifo_filter_pkg::PONLY_BIT];
          if (!nd[4]) begin // [RQ5]
            depth_q[g] <= nd;
          end
        end
      end
    end

    // clear request completes in the cycle after it is set
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        clr_q[g] <= 1'b0;
      end else if (clr_q[g]) begin
        clr_q[g] <= 1'b0; // [RQ6]
      end else if (wr_ctl && nctl[can_fifo_filter_pkg::CLR_BIT]) begin
        clr_q[g] <= 1'b1;
      end
    end

    // user-side index: head on tx, tail on rx
    always_ff @(posedge clk_i) begin
      if (rst_i || clr_q[g]) begin
        uidx_q[g] <= 5'h00;
      end else if (adv) begin
        uidx_q[g] <= unxt; // [RQ7] [RQ8]
      end
    end

    // engine-side index: next to send on tx, next to fill on rx
    always_ff @(posedge clk_i) begin
      if (rst_i || clr_q[g]) begin
        cidx_q[g] <= 5'h00;
      end else if (can_step_i[g]) begin
        cidx_q[g] <= cnxt; // [RQ17] [RQ18]
      end
    end

    // transmit status; an event in the read cycle beats the read clear
    always_ff @(posedge clk_i) begin
      if (rst_i || clr_q[g]) begin
        abt_q[g]  <= 1'b0;
        lost_q[g] <= 1'b0;
        err_q[g]  <= 1'b0;
      end else begin
        if (tx_abort_i[g]) begin
          abt_q[g] <= 1'b1; // [RQ11]
        end else if (tx_done_i[g]) begin
          abt_q[g] <= 1'b0; // [RQ11]
        end
        if (tx_lost_i[g]) begin
          lost_q[g] <= 1'b1;
        end else if (rd_ctl) begin
          lost_q[g] <= 1'b0; // [RQ12]
        end
        if (tx_err_i[g]) begin
          err_q[g] <= 1'b1;
        end else if (rd_ctl) begin
          err_q[g] <= 1'b0; // [RQ12]
        end
      end
    end

    assign fifo_tx_o[g]      = dir_q[g];
    assign payload_only_o[g] = ponly_q[g] & ~dir_q[g];

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_clr_set;
      !clr_q[g] ##1 clr_q[g];
    endsequence

    sequence s_clr_done;
      !clr_q[g] && uidx_q[g] == 5'h00 && cidx_q[g] == 5'h00 && !abt_q[g];
    endsequence

    sequence s_flags_idle;
      !lost_q[g] && !err_q[g];
    endsequence

    a_std_match: // [RQ1]
      assert property (@(posedge clk_i) disable iff (rst_i)
        hit_q[g] |-> $past(rx_id_i[28:18]) == $past(flt_q[g][31:21]))
      else $error("filter hit with standard id mismatch");

    a_ext_select: // [RQ2]
      assert property (@(posedge clk_i) disable iff (rst_i)
        hit_q[g] |-> $past(rx_ext_i) == $past(flt_q[g][19]))
      else $error("filter hit on wrong frame type");

    a_ext_match: // [RQ3]
      assert property (@(posedge clk_i) disable iff (rst_i)
        hit_q[g] && $past(rx_ext_i) |-> $past(rx_id_i[17:0]) == $past(flt_q[g][17:0]))
      else $error("filter hit with extended id mismatch");

    a_filter_lock: // [RQ4]
      assert property (@(posedge clk_i) disable iff (rst_i)
        fen_q[g] |=> $stable(flt_q[g]))
      else $error("enabled filter value changed");

    a_depth_legal: // [RQ5]
      assert property (@(posedge clk_i) disable iff (rst_i)
        !depth_q[g][4])
      else $error("reserved depth code stored");

    a_clear_seq: // [RQ6]
      assert property (@(posedge clk_i) disable iff (rst_i)
        s_clr_set |=> s_clr_done)
      else $error("fifo clear did not finish in one cycle");

    a_user_step: // [RQ8]
      assert property (@(posedge clk_i) disable iff (rst_i)
        adv && !clr_q[g] && uidx_q[g] != depth_q[g]
        |=> uidx_q[g] == $past(uidx_q[g]) + 5'h01)
      else $error("pointer advance did not move one slot");

    a_cfg_guard: // [RQ10]
      assert property (@(posedge clk_i) disable iff (rst_i)
        !cfg_w |=> $stable(depth_q[g]) && $stable(ponly_q[g]))
      else $error("depth changed outside configuration mode");

    a_read_clear: // [RQ12]
      assert property (@(posedge clk_i) disable iff (rst_i)
        rd_ctl && !tx_lost_i[g] && !tx_err_i[g] |=> !lost_q[g] && !err_q[g])
      else $error("status flags survived a control read");

    a_abort_flag: // [RQ11]
      assert property (@(posedge clk_i) disable iff (rst_i)
        tx_abort_i[g] && !clr_q[g] |=> abt_q[g])
      else $error("abort event not recorded");

    // index stepping, status flags, direction, depth, hit and payload-only; a clear in the same cycle wins for indices and flags
    a_tx_head: // [RQ7]
      assert property (@(posedge clk_i) disable iff (rst_i)
        adv && !clr_q[g] && dir_q[g] && uidx_q[g] != depth_q[g]
        |=> uidx_q[g] == $past(uidx_q[g]) + 5'h01)
      else $error("transmit head did not move one slot");

    a_head_wrap: // [RQ5]
      assert property (@(posedge clk_i) disable iff (rst_i)
        adv && !clr_q[g] && uidx_q[g] == depth_q[g] |=> uidx_q[g] == 5'h00)
      else $error("user index did not wrap after the last slot");

    a_index_step: // [RQ17] [RQ18]
      assert property (@(posedge clk_i) disable iff (rst_i)
        can_step_i[g] && !clr_q[g] && cidx_q[g] != depth_q[g]
        |=> cidx_q[g] == $past(cidx_q[g]) + 5'h01)
      else $error("side index did not move one slot");

    a_index_hold: // [RQ18]
      assert property (@(posedge clk_i) disable iff (rst_i)
        !can_step_i[g] && !clr_q[g] |=> $stable(cidx_q[g]))
      else $error("side index moved without a step");

    a_dir_write: // [RQ19]
      assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctl |=> dir_q[g] == $past(nctl[can_fifo_filter_pkg::DIR_BIT]))
      else $error("direction bit not taken from the write");

    a_depth_write: // [RQ10]
      assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctl && cfg_w && !nd[4] |=> depth_q[g] == $past(nd))
      else $error("legal depth write in configuration mode was lost");

    a_done_clear: // [RQ11]
      assert property (@(posedge clk_i) disable iff (rst_i)
        tx_done_i[g] && !tx_abort_i[g] && !clr_q[g] |=> !abt_q[g])
      else $error("completed transmission left the aborted flag set");

    a_lost_set: // [RQ12]
      assert property (@(posedge clk_i) disable iff (rst_i)
        tx_lost_i[g] && !clr_q[g] |=> lost_q[g])
      else $error("lost arbitration event not recorded");

    a_clear_flags: // [RQ12]
      assert property (@(posedge clk_i) disable iff (rst_i)
        s_clr_set |=> s_flags_idle)
      else $error("fifo clear left a transmit status flag set");

    a_clear_pulse: // [RQ6]
      assert property (@(posedge clk_i) disable iff (rst_i)
        clr_q[g] |=> !clr_q[g])
      else $error("clear request bit stayed set");

    a_hit_enable: // [RQ20]
      assert property (@(posedge clk_i) disable iff (rst_i)
        hit_q[g] |-> $past(fen_q[g]))
      else $error("disabled filter reported a hit");

    a_payload_tx: // [RQ9]
      assert property (@(posedge clk_i) disable iff (rst_i)
        dir_q[g] |-> !payload_only_o[g])
      else $error("payload-only reported on a transmit fifo");

  end

  assign filter_hit_o = hit_q;

endmodule : can_fifo_filter_regs

// ==== src/can_fifo_filter_pkg.sv ====
// Operation
// RQ1: filter bits 31-21 hold the standard id; each id bit must match.
// RQ2: extended-select bit 19 set accepts extended frames only, clear standard only.
// RQ3: filter bits 17-0 hold extended id bits; each must match on extended frames.
// RQ4: filter value writes take effect only while that filter is disabled.
// RQ5: 5-bit depth field, code 00000 is one message; codes 10000-11111 reserved.
// RQ6: clear request resets the FIFO, hardware drops the bit when done.
// RQ7: transmit FIFO: pointer advance moves the head by one slot.
// RQ8: receive FIFO: pointer advance moves the tail by one slot.
// RQ9: receive FIFO with payload-only stores data only; no effect on transmit.
// RQ10: depth and payload-only change only in configuration mode, code 100.
// RQ11: aborted flag updates on completion or abort, clears on FIFO clear.
// RQ12: lost-arbitration and error flags clear on control read or FIFO clear.
// RQ13: transmit FIFO user pointer reads the head message address.
// RQ14: receive FIFO user pointer reads the tail message address.
// RQ15: the two low bits of the user pointer always read zero.
// RQ16: software reads the user pointer only outside configuration mode.
// RQ17: transmit FIFO side index gives the next message to transmit.
// RQ18: receive FIFO side index gives the slot for the next received message.
// RQ19: direction bit set means transmit, clear means receive.
// RQ20: enabled filter hits only on matching frame type and all relevant id bits.
package can_fifo_filter_pkg;

  localparam int          N_CH       = 16;
  // byte offsets of register banks, one word per channel, and of the shared mode and filter enable words
  localparam logic [8:0]  OFF_FILTER = 9'h000;
  localparam logic [8:0]  OFF_CTRL   = 9'h040;
  localparam logic [8:0]  OFF_UPTR   = 9'h080;
  localparam logic [8:0]  OFF_CIDX   = 9'h0C0;
  localparam logic [8:0]  OFF_MODE   = 9'h100;
  localparam logic [8:0]  OFF_FEN    = 9'h104;
  // filter value fields
  localparam int          STD_HI     = 31;
  localparam int          STD_LO     = 21;
  localparam int          EXT_BIT    = 19;
  localparam int          EXT_HI     = 17;
  localparam logic [31:0] FLT_MASK   = 32'hFFEB_FFFF;
  // fifo control fields
  localparam int          DEPTH_LO   = 16;
  localparam int          CLR_BIT    = 14;
  localparam int          ADV_BIT    = 13;
  localparam int          PONLY_BIT  = 12;
  localparam int          DIR_BIT    = 7;
  localparam int          ABT_BIT    = 6;
  localparam int          LARB_BIT   = 5;
  localparam int          ERR_BIT    = 4;
  // modes and reset values
  localparam logic [2:0]  MODE_CFG   = 3'h4;
  localparam logic [2:0]  MODE_RST   = 3'h4;
  localparam logic [31:0] FLT_RST    = 32'h0000_0000;
  localparam logic [4:0]  DEPTH_RST  = 5'h00;
  // message memory layout seen by software
  localparam logic [31:0] MSG_BASE   = 32'h0000_1000;
  localparam logic [31:0] FIFO_SPAN  = 32'h0000_0200;
  localparam logic [31:0] SLOT_FULL  = 32'h0000_0010;
  localparam logic [31:0] SLOT_DATA  = 32'h0000_0008;

endpackage : can_fifo_filter_pkg

// ==== dv/can_engine_model.sv ====
module can_engine_model (
  // clock
  input  wire logic        clk_i,
  // frame identifier seen on the bus
  output logic      [28:0] rx_id_o,
  output logic             rx_ext_o,
  // per fifo event pulses
  output logic      [15:0] step_o,
  output logic      [15:0] done_o,
  output logic      [15:0] abort_o,
  output logic      [15:0] lost_o,
  output logic      [15:0] err_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // quiet lines at time zero
  initial begin
    rx_id_o = 29'h0000_0000;
    rx_ext_o = 1'b0;
    {step_o, done_o, abort_o, lost_o, err_o} = 80'h0;
  end

  ////////////////////////////////////////
  // id lives one cycle; afterwards the inverse, so a stale id never matches by luck
  task automatic send_id(input logic [28:0] id, input logic ext);
    @(posedge clk_i);
    rx_id_o <= id;
    rx_ext_o <= ext;
    @(posedge clk_i);
    rx_id_o <= ~id;
    rx_ext_o <= ~ext;
  endtask : send_id

  // kind 0 step, 1 done, 2 abort, 3 lost, 4 error; one-cycle pulse on fifo ch
  task automatic pulse(input int kind, input int ch);
    logic [15:0] m;
    m = 16'h0001 << ch;
    @(posedge clk_i);
    case (kind)
      0: step_o <= m;
      1: done_o <= m;
      2: abort_o <= m;
      3: lost_o <= m;
      default: err_o <= m;
    endcase
    @(posedge clk_i);
    {step_o, done_o, abort_o, lost_o, err_o} <= 80'h0;
  endtask : pulse
endmodule : can_engine_model

// ==== dv/can_fifo_filter_regs_tb.sv ====
module can_fifo_filter_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [8:0] FLT = can_fifo_filter_pkg::OFF_FILTER;
  localparam logic [8:0] CTL = can_fifo_filter_pkg::OFF_CTRL;
  localparam logic [8:0] UPA = can_fifo_filter_pkg::OFF_UPTR;
  localparam logic [8:0] CIX = can_fifo_filter_pkg::OFF_CIDX;
  localparam logic [8:0] MOD = can_fifo_filter_pkg::OFF_MODE;
  localparam logic [8:0] FEN = can_fifo_filter_pkg::OFF_FEN;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, rx_ext;
  logic [8:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o;
  logic [28:0] rx_id;
  logic [15:0] step, done, abort, lost, err, hit, tx_dir, ponly;
  logic [2:0]  mode;
  int          n_mismatch, checks_done;

  can_fifo_filter_regs can_fifo_filter_regs_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .rx_id_i(rx_id), .rx_ext_i(rx_ext), .can_step_i(step), .tx_done_i(done),
    .tx_abort_i(abort), .tx_lost_i(lost), .tx_err_i(err), .filter_hit_o(hit),
    .fifo_tx_o(tx_dir), .payload_only_o(ponly), .op_mode_o(mode));
  can_engine_model can_engine_model_i (.clk_i(clk_i), .rx_id_o(rx_id), .rx_ext_o(rx_ext),
    .step_o(step), .done_o(done), .abort_o(abort), .lost_o(lost), .err_o(err));

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // classic cycle: held until ack, released at that edge; the next call leaves a gap
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask : rd

  task automatic try_id(input logic [28:0] id, input logic ext, input logic [15:0] e);
    can_engine_model_i.send_id(id, ext);
    @(posedge clk_i);
    chk({16'h0000, hit}, {16'h0000, e});
  endtask : try_id

  ////////////////////////////////////////
  task automatic t_reset();
    rd(FLT, 32'h0000_0000);
    rd(CTL, 32'h0000_0000);
    rd(UPA, 32'h0000_1000);
    wr(9'h108, 32'hFFFF_FFFF);
    rd(9'h108, 32'h0000_0000);
  endtask : t_reset

  task automatic t_filter();
    wr(FLT, 32'hB4A0_0000);
    wr(FLT + 9'h004, 32'h246A_5A5A);
    wr(FEN, 32'h0000_0003);
    try_id({11'h5A5, 18'h3_FFFF}, 1'b0, 16'h0001);
    try_id({11'h5A4, 18'h0_0000}, 1'b0, 16'h0000);
    try_id({11'h123, 18'h2_5A5A}, 1'b1, 16'h0002);
    try_id({11'h123, 18'h2_5A5B}, 1'b1, 16'h0000);
    try_id({11'h5A5, 18'h0_0000}, 1'b1, 16'h0000);
    try_id({11'h123, 18'h2_5A5A}, 1'b0, 16'h0000);
    wr(FLT, 32'hFFFF_FFFF);
    rd(FLT, 32'hB4A0_0000);
    wr(FEN, 32'h0000_0000);
    wr(FLT, 32'hFFFF_FFFF);
    rd(FLT, can_fifo_filter_pkg::FLT_MASK);
    try_id(29'h1FFF_FFFF, 1'b1, 16'h0000);
  endtask : t_filter

  task automatic t_config();
    rd(MOD, 32'h0000_0004);
    wr(CTL + 9'h008, 32'h0003_1000);
    wr(CTL + 9'h00C, 32'h0007_1080);
    wr(CTL + 9'h008, 32'h0010_1000);
    rd(CTL + 9'h008, 32'h0003_1000);
    chk({16'h0000, ponly}, 32'h0000_0004);
    chk({16'h0000, tx_dir}, 32'h0000_0008);
    wr(MOD, 32'h0000_0000);
    wr(CTL + 9'h008, 32'h0001_0000);
    rd(CTL + 9'h008, 32'h0003_1000);
    chk({29'h0000_0000, mode}, 32'h0000_0000);
  endtask : t_config

  // reads of the user pointer happen only outside configuration mode
  task automatic t_pointer();
    rd(UPA + 9'h008, 32'h0000_1400);
    for (int k = 1; k <= 4; k++) begin
      wr(CTL + 9'h008, 32'h0000_2000);
      rd(UPA + 9'h008, 32'h0000_1400 + 32'(k % 4) * 32'h0000_0008);
    end
    repeat (2) wr(CTL + 9'h00C, 32'h0000_2080);
    rd(UPA + 9'h00C, 32'h0000_1620);
    repeat (5) can_engine_model_i.pulse(0, 2);
    repeat (3) can_engine_model_i.pulse(0, 3);
    rd(CIX + 9'h008, 32'h0000_0001);
    rd(CIX + 9'h00C, 32'h0000_0003);
  endtask : t_pointer

  task automatic t_flags();
    logic [31:0] q;
    can_engine_model_i.pulse(3, 3);
    can_engine_model_i.pulse(4, 3);
    rd(CTL + 9'h00C, 32'h0007_10B0);
    rd(CTL + 9'h00C, 32'h0007_1080);
    can_engine_model_i.pulse(2, 3);
    rd(CTL + 9'h00C, 32'h0007_10C0);
    can_engine_model_i.pulse(1, 3);
    rd(CTL + 9'h00C, 32'h0007_1080);
    can_engine_model_i.pulse(2, 3);
    can_engine_model_i.pulse(3, 3);
    wr(CTL + 9'h00C, 32'h0000_4080);
    do wb(1'b0, CTL + 9'h00C, 32'h0000_0000, q); while (q[14] !== 1'b0);
    rd(CTL + 9'h00C, 32'h0007_1080);
    rd(CIX + 9'h00C, 32'h0000_0000);
    rd(UPA + 9'h00C, 32'h0000_1600);
  endtask : t_flags

  ////////////////////////////////////////
  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end

  // main sequence
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 9'h000;
    sel_i = 4'hF;
    dat_i = 32'h0000_0000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_filter();
    t_config();
    t_pointer();
    t_flags();
    end_of_test();
  end
endmodule : can_fifo_filter_regs_tb
